// file: src/ebr_bus_engine.sv
// ebr_bus_engine: external bus cycle engine with ready extension and hold arbitration.
// assumes an AHB-Lite master with single word transfers; pins synchronous to hclk.
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
module ebr_bus_engine
    import ebr_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic system_clock_output,
    output logic [ADDR_W-1:0] ext_addr,
    output logic [DATA_W-1:0] ext_data_out,
    output logic ext_data_oe,
    input wire logic [DATA_W-1:0] ext_data_in,
    output logic addr_latch_en,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic bus_drive_en,
    input wire logic ready_n,
    input wire logic hold_request_n,
    output logic bus_release_grant_n,
    output logic bus_regain_request_n
);

    // ***************************************************************
    // parameter checks
    // ***************************************************************
    if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1 || DATA_W > 16) begin : g_bad_width
        $error("ebr_bus_engine: widths must lie between 1 and 16");
    end

    // ***************************************************************
    // declarations
    // ***************************************************************
    logic tick, clk_out;
    ebr_cfg_type cfg_ff;
    logic [ADDR_W-1:0] addr_reg_ff;
    logic [DATA_W-1:0] wdata_reg_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [7:0] waits_ff;
    logic pend_ff, pend_we_ff, done_ff, cyc_we_ff;
    logic [3:0] ws_cnt_ff;
    logic [1:0] gap_cnt_ff;
    logic regain_seen_ff, held_one_ff;
    ebr_state_type state_ff, nxt_state;
    logic wr_pend_ff;
    logic [7:0] wr_ofs_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic clk_pin_ff;
    logic [ADDR_W-1:0] ext_addr_ff;
    logic [DATA_W-1:0] ext_dout_ff;
    logic ext_doe_ff;
    logic ale_ff, rd_n_ff, wr_n_ff, drive_ff, grant_n_ff, bus_regain_request_n_ff;
    logic addr_phase, start_wr, cycle_end;
    logic [1:0] gap_need;

    // gap: mux wait state plus optional tristate one
    function automatic logic [1:0] gap_len(input ebr_cfg_type c);
        return (c.mux_mode ? 2'(EBR_MUX_GAP_CYCLES) : 2'h0) + (c.tri_ws ? 2'(EBR_TRI_GAP_CYCLES) : 2'h0);
    endfunction

    // ***************************************************************
    // clock output
    // ***************************************************************
    ebr_system_clock_output_gen u_clkgen (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_out(clk_out),
        .tick(tick)
    );

    // re-timed so the pin comes from a flop, one hclk behind the divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_pin_ff <= 1'b0;
        end else begin
            clk_pin_ff <= clk_out;
        end
    end

    // ***************************************************************
    // AHB-Lite slave
    // ***************************************************************
    assign addr_phase = hsel & htrans[1] & hready;
    assign start_wr = wr_pend_ff && (wr_ofs_ff == EBR_CMD_OFS) && hwdata[EBR_CMD_START_BIT];
    assign gap_need = gap_len(cfg_ff);

    // write address phase held for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_ofs_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_phase & hwrite;
            wr_ofs_ff <= haddr[7:0];
        end
    end

    // zero wait states; read data ready for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            hreadyout_ff <= 1'b1;
            if (addr_phase && !hwrite) begin
                unique case (haddr[7:0])
                    EBR_CFG_OFS: hrdata_ff <= {24'h00_0000, cfg_ff};
                    EBR_ADDR_OFS: hrdata_ff <= 32'(addr_reg_ff);
                    EBR_WDATA_OFS: hrdata_ff <= 32'(wdata_reg_ff);
                    EBR_STAT_OFS: begin
                        hrdata_ff <= 32'h0000_0000;
                        hrdata_ff[EBR_ST_BUSY_BIT] <= pend_ff | (state_ff != ST_IDLE);
                        hrdata_ff[EBR_ST_DONE_BIT] <= done_ff;
                        hrdata_ff[EBR_ST_GRANT_BIT] <= ~grant_n_ff;
                        hrdata_ff[EBR_ST_REGAIN_BIT] <= regain_seen_ff;
                        hrdata_ff[EBR_ST_WAITS_LSB +: 8] <= waits_ff;
                    end
                    EBR_RDATA_OFS: hrdata_ff <= 32'(rdata_ff);
                    default: hrdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff <= EBR_CFG_RESET;
            addr_reg_ff <= '0;
            wdata_reg_ff <= '0;
        end else if (wr_pend_ff) begin
            unique case (wr_ofs_ff)
                EBR_CFG_OFS: cfg_ff <= hwdata[7:0];
                EBR_ADDR_OFS: addr_reg_ff <= hwdata[ADDR_W-1:0];
                EBR_WDATA_OFS: wdata_reg_ff <= hwdata[DATA_W-1:0];
                default: ;
            endcase
        end
    end

    // pending command; a start while busy is ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_ff <= 1'b0;
            pend_we_ff <= 1'b0;
        end else if (start_wr && !pend_ff && state_ff == ST_IDLE) begin
            pend_ff <= 1'b1;
            pend_we_ff <= hwdata[EBR_CMD_WRITE_BIT];
        end else if (tick && state_ff == ST_IDLE && pend_ff && hold_request_n) begin
            pend_ff <= 1'b0;
        end
    end

    // ***************************************************************
    // bus state machine, one step per clock output cycle
    // ***************************************************************
    assign cycle_end = (state_ff == ST_CMD) && (ws_cnt_ff == 4'h0) && !ready_n;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (!hold_request_n) begin
                    nxt_state = ST_REL; // only granted between cycles
                end else if (pend_ff) begin
                    nxt_state = ST_ADDR;
                end
            end
            ST_ADDR: nxt_state = cfg_ff.rw_delay ? ST_DLY : ST_CMD;
            ST_DLY: nxt_state = ST_CMD;
            ST_CMD: begin
                if (cycle_end) begin
                    nxt_state = (gap_need != 2'h0) ? ST_GAP : ST_IDLE;
                end
            end
            ST_GAP: begin
                if (gap_cnt_ff == 2'h1) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_REL: nxt_state = ST_HELD;
            ST_HELD: begin
                if (hold_request_n) begin
                    nxt_state = ST_REGAIN;
                end
            end
            ST_REGAIN: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // hold request sampled only on clock output rising edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_IDLE;
        end else if (tick) begin
            state_ff <= nxt_state;
        end
    end

    // programmed wait states, then ready decides
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ws_cnt_ff <= 4'h0;
            waits_ff <= 8'h00;
        end else if (tick) begin
            if (state_ff == ST_ADDR || state_ff == ST_DLY) begin
                ws_cnt_ff <= cfg_ff.memory_cycle_time_setting_ws;
                waits_ff <= 8'h00;
            end else if (state_ff == ST_CMD) begin
                if (ws_cnt_ff != 4'h0) begin
                    ws_cnt_ff <= ws_cnt_ff - 4'h1;
                end else if (ready_n && waits_ff != 8'hff) begin
                    waits_ff <= waits_ff + 8'h01; // one cycle, sample again
                end
            end
        end
    end

    // gap counter for mux and tristate wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_cnt_ff <= 2'h0;
        end else if (tick) begin
            if (cycle_end) begin
                gap_cnt_ff <= gap_need;
            end else if (state_ff == ST_GAP) begin
                gap_cnt_ff <= gap_cnt_ff - 2'h1;
            end
        end
    end

    // cycle direction, read capture and done flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_we_ff <= 1'b0;
            rdata_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            if (tick && cycle_end) begin
                done_ff <= 1'b1; // set wins over the clear below
                if (!cyc_we_ff) begin
                    rdata_ff <= ext_data_in;
                end
            end else if (start_wr && !pend_ff && state_ff == ST_IDLE) begin
                done_ff <= 1'b0;
            end
            if (tick && state_ff == ST_IDLE && pend_ff && hold_request_n) begin
                cyc_we_ff <= pend_we_ff;
            end
        end
    end

    // ***************************************************************
    // arbitration: grant, regain request
    // ***************************************************************
    // held_one: one full cycle passed with grant on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_one_ff <= 1'b0;
            regain_seen_ff <= 1'b0;
        end else if (tick) begin
            held_one_ff <= (state_ff == ST_HELD);
            if (state_ff == ST_REL) begin
                regain_seen_ff <= 1'b0;
            end else if (state_ff == ST_HELD && hold_request_n) begin
                regain_seen_ff <= ~bus_regain_request_n_ff; // last point before regain
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grant_n_ff <= 1'b1;
            bus_regain_request_n_ff <= 1'b1;
            drive_ff <= 1'b1;
        end else if (tick) begin
            unique case (nxt_state)
                ST_REL: begin
                    drive_ff <= 1'b0; // release first
                end
                ST_HELD: begin
                    grant_n_ff <= 1'b0;
                    // never in the grant cycle itself; wanted when work waits
                    bus_regain_request_n_ff <= ~(held_one_ff & (pend_ff | cfg_ff.regain_en));
                end
                ST_REGAIN: begin
                    grant_n_ff <= 1'b1;
                    bus_regain_request_n_ff <= 1'b1;
                end
                ST_IDLE: begin
                    drive_ff <= 1'b1; // bus driven again
                end
                default: ;
            endcase
        end
    end

    // ***************************************************************
    // pin drivers
    // ***************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_addr_ff <= '0;
            ext_dout_ff <= '0;
            ext_doe_ff <= 1'b0;
            ale_ff <= 1'b0;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
        end else if (tick) begin
            ale_ff <= (nxt_state == ST_ADDR);
            // strobe low only in the command phase; rises when ready ends it
            rd_n_ff <= ~(nxt_state == ST_CMD && !cyc_we_eff());
            wr_n_ff <= ~(nxt_state == ST_CMD && cyc_we_eff());
            if (nxt_state == ST_ADDR) begin
                ext_addr_ff <= addr_reg_ff;
                // mux bus puts the address on data pins
                ext_dout_ff <= DATA_W'(addr_reg_ff);
                ext_doe_ff <= cfg_ff.mux_mode;
            end else if (nxt_state == ST_DLY || nxt_state == ST_CMD) begin
                ext_dout_ff <= wdata_reg_ff;
                ext_doe_ff <= cyc_we_eff();
            end else begin
                ext_doe_ff <= 1'b0;
            end
        end
    end

    // direction of the next or running cycle
    function automatic logic cyc_we_eff();
        return (state_ff == ST_IDLE) ? pend_we_ff : cyc_we_ff;
    endfunction

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign system_clock_output = clk_pin_ff;
    assign ext_addr = ext_addr_ff;
    assign ext_data_out = ext_dout_ff;
    assign ext_data_oe = ext_doe_ff;
    assign addr_latch_en = ale_ff;
    assign read_strobe_n = rd_n_ff;
    assign write_strobe_n = wr_n_ff;
    assign bus_drive_en = drive_ff;
    assign bus_release_grant_n = grant_n_ff;
    assign bus_regain_request_n = bus_regain_request_n_ff;

endmodule

// file: src/ebr_pkg.sv
// ebr_pkg: constants and types of the bus engine.
// assumes one 125 MHz hclk domain; the bus steps once per output cycle.
//
// Function
// - ready high at its sampling point adds a wait state; low ends the cycle.
// - each cycle first runs its programmed length with memory wait states.
// - the strobe leads early without read/write delay and later with it.
// - a multiplexed bus adds a gap wait state, one more with tristate.
// - after these delays the next external cycle may start at once.
// - hold is sampled, and grant and regain request change, on clock output edges.
// - hold is granted only after the running cycle has finished.
// - regain request comes no earlier than the clock output cycle after grant.
// - regain starts only when the other master drops hold.
// - a regain request counts only if raised by the last point before regain.
// - after regain, grant goes, the bus is driven and a new cycle may start.
package ebr_pkg;

    // ***************************************************************
    // register map (byte addresses)
    // ***************************************************************
    localparam logic [7:0] EBR_CFG_OFS = 8'h00;
    localparam logic [7:0] EBR_ADDR_OFS = 8'h04;
    localparam logic [7:0] EBR_WDATA_OFS = 8'h08;
    localparam logic [7:0] EBR_CMD_OFS = 8'h0c;
    localparam logic [7:0] EBR_STAT_OFS = 8'h10;
    localparam logic [7:0] EBR_RDATA_OFS = 8'h14;

    // config fields
    localparam int EBR_CFG_MEMORY_CYCLE_TIME_SETTING_LSB = 0;
    localparam int EBR_CFG_RWDLY_BIT = 4;
    localparam int EBR_CFG_MUX_BIT = 5;
    localparam int EBR_CFG_TRI_BIT = 6;
    localparam int EBR_CFG_REGAIN_BIT = 7;
    localparam logic [7:0] EBR_CFG_RESET = 8'h00;

    // command fields
    localparam int EBR_CMD_START_BIT = 0;
    localparam int EBR_CMD_WRITE_BIT = 1;

    // status fields
    localparam int EBR_ST_BUSY_BIT = 0;
    localparam int EBR_ST_DONE_BIT = 1;
    localparam int EBR_ST_GRANT_BIT = 2;
    localparam int EBR_ST_REGAIN_BIT = 3;
    localparam int EBR_ST_WAITS_LSB = 8;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int EBR_HCLK_MHZ = 125;
    localparam int EBR_READY_LOW_EXTRA_NS = 15;
    localparam int EBR_MUX_GAP_CYCLES = 1;
    localparam int EBR_TRI_GAP_CYCLES = 1;

    // ***************************************************************
    // types
    // ***************************************************************
    typedef struct packed {
        logic regain_en;
        logic tri_ws;
        logic mux_mode;
        logic rw_delay;
        logic [3:0] memory_cycle_time_setting_ws;
    } ebr_cfg_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_DLY = 4'h2,
        ST_CMD = 4'h3,
        ST_GAP = 4'h4,
        ST_REL = 4'h5,
        ST_HELD = 4'h6,
        ST_REGAIN = 4'h7
    } ebr_state_type;

endpackage

// file: src/ebr_system_clock_output_gen.sv
// ebr_system_clock_output_gen: clock output at half hclk.
// assumes a free running hclk; tick marks the rising step.
module ebr_system_clock_output_gen
    import ebr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    output logic clk_out,
    output logic tick
);

    logic clk_ff;
    logic tick_ff;

    // ***************************************************************
    // divider: one hclk per half clock period
    // ***************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_ff <= 1'b0;
        end else begin
            clk_ff <= ~clk_ff;
        end
    end

    // tick high before the edge raising the output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= clk_ff;
        end
    end

    assign clk_out = clk_ff;
    assign tick = tick_ff;

endmodule

// file: tb/ebr_bus_engine_properties.sv
// checker: pin timing of the bus engine
// assumes one hclk domain, async active low reset
module ebr_bus_engine_checker
    import ebr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic addr_latch_en,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic bus_drive_en,
    input wire logic ext_data_oe,
    input wire logic ready_n,
    input wire logic hold_request_n,
    input wire logic bus_release_grant_n,
    input wire logic bus_regain_request_n
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // no command phase
    logic cmd_idle;
    assign cmd_idle = read_strobe_n & write_strobe_n;
    // drive back one step after grant goes
    sequence regain_seq;
        !bus_drive_en ##2 bus_drive_en;
    endsequence
    sequence released_seq;
        cmd_idle && !addr_latch_en && !ext_data_oe;
    endsequence
    ahb_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer bad");
    cycle_end_a: assert property ($rose(cmd_idle) |-> !$past(ready_n))
        else $error("end without ready");
    wait_hold_a: assert property (!cmd_idle && ready_n |=> !cmd_idle)
        else $error("end while ready high");
    min_strobe_a: assert property ($fell(cmd_idle) |-> !cmd_idle [*2])
        else $error("strobe too short");
    ale_apart_a: assert property (addr_latch_en |-> cmd_idle)
        else $error("latch overlaps strobe");
    quiet_release_a: assert property (!bus_drive_en |-> released_seq)
        else $error("pins active released");
    grant_after_a: assert property ($fell(bus_release_grant_n) |-> !$past(bus_drive_en, 2) && cmd_idle)
        else $error("grant before release");
    bus_regain_request_late_a: assert property ($fell(bus_regain_request_n) |-> !$past(bus_release_grant_n, 2))
        else $error("regain req early");
    edge_step_a: assert property ($changed({bus_release_grant_n, bus_regain_request_n}) |=>
        $stable({bus_release_grant_n, bus_regain_request_n})) else $error("pin off step");
    regain_order_a: assert property ($rose(bus_release_grant_n) |-> $past(hold_request_n) ##0 regain_seq)
        else $error("regain out of order");
endmodule

bind ebr_bus_engine ebr_bus_engine_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .addr_latch_en(addr_latch_en), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .bus_drive_en(bus_drive_en), .ext_data_oe(ext_data_oe), .ready_n(ready_n), .hold_request_n(hold_request_n),
    .bus_release_grant_n(bus_release_grant_n), .bus_regain_request_n(bus_regain_request_n));

// file: tb/ebr_ext_model.sv
// far side: 16 word memory with ready, and a second master
// assumes pins move on hclk edges; wait_len is the ready delay in hclk
module ebr_ext_model (
    input wire logic hclk,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] ext_data_out,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] wait_len,
    input wire logic want_bus,
    output logic [15:0] ext_data_in,
    output logic ready_n,
    output logic hold_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [7:0] low_cnt;
    logic [1:0] tail;
    // ****************************************
    // behaviour
    // ****************************************
    initial begin
        ready_n = 1'b1;
        hold_request_n = 1'b1;
        ext_data_in = 16'h5a5a;
        low_cnt = 8'h00;
        tail = 2'h0;
    end
    // ready stays two edges past the strobe for a slow sampler
    always @(posedge hclk) begin
        if (!read_strobe_n || !write_strobe_n) begin
            low_cnt <= low_cnt + 8'h01;
            tail <= 2'h0;
            if (low_cnt + 8'h01 >= wait_len) ready_n <= 1'b0;
        end else begin
            low_cnt <= 8'h00;
            if (tail == 2'h2) ready_n <= 1'b1;
            else tail <= tail + 2'h1;
        end
    end
    // idle data lines toggle, never hold
    always @(posedge hclk) begin
        if (!write_strobe_n) mem[ext_addr[3:0]] <= ext_data_out;
        ext_data_in <= read_strobe_n ? ~ext_data_in : mem[ext_addr[3:0]];
    end
    // other master takes and drops the bus at will
    always @(posedge hclk) hold_request_n <= !want_bus;
endmodule

// file: tb/test_ext_bus_ready_hold_arbitration.sv
// bench: bus master, far side model and pin timing checks
// assumes the ebr_pkg register map
module test_ext_bus_ready_hold_arbitration
    import ebr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, want_bus = 1'b0, dchk = 1'b0, bus_regain_request_seen = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lead = 32'h0, low_len = 32'h0;
    logic [7:0] wait_len = 8'h01;
    logic [15:0] seed = 16'h0003, ext_addr, ext_data_out, ext_data_in;
    logic hreadyout, hresp, ext_data_oe, addr_latch_en, read_strobe_n, write_strobe_n, bus_drive_en;
    logic ready_n, hold_request_n, bus_release_grant_n, bus_regain_request_n;
    logic [31:0] exp_q[$], msk_q[$];
    int err_total = 0, checks = 0;
    always #4 hclk = ~hclk;
    ebr_bus_engine dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .system_clock_output(), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
        .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in), .addr_latch_en(addr_latch_en),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .bus_drive_en(bus_drive_en),
        .ready_n(ready_n), .hold_request_n(hold_request_n), .bus_release_grant_n(bus_release_grant_n),
        .bus_regain_request_n(bus_regain_request_n));
    ebr_ext_model far (.hclk(hclk), .ext_addr(ext_addr), .ext_data_out(ext_data_out), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .wait_len(wait_len), .want_bus(want_bus), .ext_data_in(ext_data_in),
        .ready_n(ready_n), .hold_request_n(hold_request_n));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // single transfer; nonzero mask queues an expected read
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] msk,
                       input logic [31:0] e, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        dchk <= (msk != 32'h0);
        if (msk != 32'h0) begin
            exp_q.push_back(e);
            msk_q.push_back(msk);
        end
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        dchk <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, 32'h0, 32'h0, r);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, msk, e, r);
    endtask
    // poll until done and idle
    task automatic wait_done();
        logic [31:0] s = 32'h0;
        for (int i = 0; i < 200 && !(s[EBR_ST_DONE_BIT] && !s[EBR_ST_BUSY_BIT]); i++)
            ahb(1'b0, EBR_STAT_OFS, 32'h0, 32'h0, 32'h0, s);
    endtask
    task automatic run(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [3:0] n);
        wait_len <= {3'h0, n, 1'b1};
        wreg(EBR_ADDR_OFS, {16'h0, a});
        wreg(EBR_WDATA_OFS, {16'h0, d});
        wreg(EBR_CMD_OFS, {30'h0, wr, 1'b1});
        wait_done();
    endtask
    // read results checked in order during the data phase
    always @(negedge hclk) begin
        if (dchk && hreadyout === 1'b1 && exp_q.size() > 0) begin
            chk(hrdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    // strobe lead and length in hclk cycles
    always @(posedge hclk) begin
        if (bus_regain_request_n === 1'b0) bus_regain_request_seen <= 1'b1;
        if (addr_latch_en) begin
            low_len <= 32'h0;
            lead <= 32'h0;
        end else if (!read_strobe_n || !write_strobe_n) low_len <= low_len + 32'h1;
        else if (low_len == 32'h0) lead <= lead + 32'h1;
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [7:0] c;
        logic [3:0] m, w;
        logic [7:0] cfg_tab [5] = '{8'h00, 8'h10, 8'h21, 8'h72, 8'h44};
        logic [3:0] n_tab [5] = '{4'h0, 4'h2, 4'h3, 4'h1, 4'h6};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rreg(EBR_CFG_OFS, 32'hffffffff, 32'h0);
        rreg(EBR_STAT_OFS, 32'hffffffff, 32'h0);
        rreg(8'h20, 32'hffffffff, 32'h0);
        for (int i = 0; i < 5; i++) begin
            c = cfg_tab[i];
            m = c[3:0];
            w = (n_tab[i] > m) ? n_tab[i] - m : 4'h0;
            wreg(EBR_CFG_OFS, {24'h0, c});
            rreg(EBR_CFG_OFS, 32'hff, {24'h0, c});
            seed = lfsr(seed);
            for (int j = 1; j >= 0; j--) begin
                run(j[0], {12'h0, i[3:0]}, seed, n_tab[i]);
                chk(lead, 2 * c[4]);
                chk(low_len, 2 * (1 + m + w));
                rreg(EBR_STAT_OFS, 32'hff03, {16'h0, 4'h0, w, 8'h02});
            end
            rreg(EBR_RDATA_OFS, 32'hffff, {16'h0, seed});
        end
        for (int i = 0; i < 2; i++) begin
            bus_regain_request_seen <= 1'b0;
            wreg(EBR_CFG_OFS, (i == 0) ? 32'h80 : 32'h0);
            wait_len <= 8'h09;
            wreg(EBR_CMD_OFS, 32'h1);
            want_bus <= 1'b1;
            for (int k = 0; k < 200 && bus_release_grant_n !== 1'b0; k++) @(posedge hclk);
            chk(32'(bus_drive_en), 32'h0);
            repeat (16) @(posedge hclk);
            rreg(EBR_STAT_OFS, 32'h4, 32'h4);
            chk(32'(bus_regain_request_seen), (i == 0) ? 32'h1 : 32'h0);
            want_bus <= 1'b0;
            wait_done();
            chk(32'(bus_release_grant_n), 32'h1);
            rreg(EBR_STAT_OFS, 32'h8, (i == 0) ? 32'h8 : 32'h0);
        end
        wrap_up();
    end
    // watchdog: run needs under 10000 cycles
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule
